// file: core/qa_watchdog_question_status.sv
`timescale 1ns/1ns
module qa_watchdog_question_status
#(
  parameter int TICK_CYCLES = qa_wd_pkg::TICK_CYCLES
)
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // device state events
  input  wire logic       reset_state,
  input  wire logic       self_test_done,
  input  wire logic       window_mode_select,
  input  wire logic       win_cfg_written,
  input  wire logic [7:0] first_window_length,
  input  wire logic [4:0] second_window_length,
  input  wire logic [3:0] failure_counter,
  input  wire logic [3:0] fail_drive_threshold,
  // register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_reg,
  output logic            cycle_end_reg
);
  logic [7:0] qcfg_reg;
  logic [3:0] question_reg;
  logic [1:0] cnt_reg;
  logic       fail_reg, chg_reg, werr_reg, seq_reg, to_reg, early_reg;
  logic       mode_reg;
  logic       bad_reg, in_win1_reg;
  logic [2:0] total_reg, win1_reg;
  logic [8:0] ticks_reg;
  logic [31:0] div_reg;
  logic       tick, ans_wr, st_rd, mode_chg, reinit, mismatch;
  logic       cycle_timeout;
  logic [5:0] cycle_len;
  logic [3:0] q_next;

  assign ans_wr = reg_wr && reg_addr == qa_wd_pkg::REG_ANSWER;
  assign st_rd = reg_rd && reg_addr == qa_wd_pkg::REG_STATUS;
  assign mode_chg = mode_reg != window_mode_select;
  assign reinit = reset_state || self_test_done || mode_chg;
  assign tick = div_reg == TICK_CYCLES - 1;
  assign cycle_len = {1'b0, second_window_length} + 6'h01;
  // time-out of the cycle now ending; the stored flag is one cycle stale
  assign cycle_timeout = mode_reg ? total_reg == 3'h0
                                  : total_reg < 3'h4;

  qa_answer_check u_check
  (
    .question (question_reg),
    .index    (total_reg[1:0]),
    .gen_sel  (qcfg_reg[qa_wd_pkg::GEN_HI -: 2]),
    .answer   (reg_wdata),
    .mismatch (mismatch)
  );

  always_ff @(posedge clk_sys)
    mode_reg <= rst ? 1'b0 : window_mode_select;

  // question config; writes lock-free here, gating lives upstream
  always_ff @(posedge clk_sys)
  begin
    if (rst || reinit)
      qcfg_reg <= qa_wd_pkg::QCFG_RESET;
    else if (reg_wr && reg_addr == qa_wd_pkg::REG_QCFG)
      qcfg_reg <= reg_wdata;
  end

  // question lfsr, polynomial picks feedback taps
  always_comb
  begin
    unique case (qcfg_reg[qa_wd_pkg::POLY_HI -: 2])
      2'h0: q_next = {question_reg[2:0], question_reg[3] ^ question_reg[2]};
      2'h1: q_next = {question_reg[2:0], question_reg[3] ^ question_reg[1]};
      2'h2: q_next = {question_reg[2:0], question_reg[3] ^ question_reg[0]};
      default: q_next = {question_reg[2:0], ~question_reg[3]};
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || self_test_done || mode_chg)
      question_reg <= qa_wd_pkg::QUESTION_RESET;
    else if (reset_state)
      question_reg <= qcfg_reg[qa_wd_pkg::SEED_HI:0];
    else if (cycle_end_reg && !bad_reg && !cycle_timeout)
      question_reg <= q_next;
  end

  // 0.55 ms time base
  always_ff @(posedge clk_sys)
  begin
    if (rst || reinit || tick)
      div_reg <= 32'h0000_0000;
    else
      div_reg <= div_reg + 32'h0000_0001;
  end

  // cycle timer: window one then window two
  always_ff @(posedge clk_sys)
  begin
    cycle_end_reg <= 1'b0;
    if (rst || reinit)
    begin
      ticks_reg <= 9'h000;
      in_win1_reg <= 1'b1;
    end
    else if (tick)
    begin
      if (in_win1_reg && ticks_reg == {1'b0, first_window_length})
      begin
        in_win1_reg <= 1'b0;
        ticks_reg <= 9'h000;
      end
      else if (!in_win1_reg && ticks_reg == {3'h0, cycle_len} - 9'h001)
      begin
        in_win1_reg <= 1'b1;
        ticks_reg <= 9'h000;
        cycle_end_reg <= 1'b1;
      end
      else
        ticks_reg <= ticks_reg + 9'h001;
    end
  end

  // per-cycle answer bookkeeping
  always_ff @(posedge clk_sys)
  begin
    if (rst || reinit || cycle_end_reg)
    begin
      total_reg <= 3'h0;
      win1_reg <= 3'h0;
      bad_reg <= 1'b0;
    end
    else if (ans_wr)
    begin
      if (total_reg != 3'h7)
        total_reg <= total_reg + 3'h1;
      if (in_win1_reg && win1_reg != 3'h7)
        win1_reg <= win1_reg + 3'h1;
      if (mismatch)
        bad_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || reinit || cycle_end_reg)
      cnt_reg <= window_mode_select ? qa_wd_pkg::CNT_SINGLE_RESET
                                    : qa_wd_pkg::CNT_MULTI_RESET;
    else if (ans_wr)
      cnt_reg <= cnt_reg - 2'h1;
  end

  // threshold flag: event wins over read clear
  always_ff @(posedge clk_sys)
  begin
    if (rst || reinit)
      fail_reg <= 1'b1;
    else if (failure_counter >= fail_drive_threshold)
      fail_reg <= 1'b1;
    else if (st_rd)
      fail_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      chg_reg <= 1'b0;
    else if (win_cfg_written || mode_chg
             || (reg_wr && reg_addr == qa_wd_pkg::REG_QCFG))
      chg_reg <= 1'b1;
    else if (st_rd)
      chg_reg <= 1'b0;
  end

  // cycle-end flags; a cycle end beats a concurrent read
  always_ff @(posedge clk_sys)
  begin
    if (rst || reinit)
    begin
      werr_reg <= 1'b0;
      seq_reg <= 1'b0;
      to_reg <= 1'b0;
      early_reg <= 1'b0;
    end
    else if (cycle_end_reg)
    begin
      werr_reg <= bad_reg;
      seq_reg <= !mode_reg && win1_reg < 3'h3;
      to_reg <= cycle_timeout;
      early_reg <= mode_reg ? win1_reg != 3'h0
                            : win1_reg >= 3'h4;
    end
    else if (st_rd)
    begin
      werr_reg <= 1'b0;
      seq_reg <= 1'b0;
      to_reg <= 1'b0;
      early_reg <= 1'b0;
    end
  end

  // read data, registered; answer register is write-only
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata_reg <= 8'h00;
    else if (reg_rd)
      unique case (reg_addr)
        qa_wd_pkg::REG_QCFG: reg_rdata_reg <= qcfg_reg;
        qa_wd_pkg::REG_QVAL: reg_rdata_reg <= {4'h0, question_reg};
        qa_wd_pkg::REG_STATUS:
          reg_rdata_reg <= {fail_reg, cnt_reg, chg_reg, werr_reg,
                            seq_reg, to_reg, early_reg};
        default: reg_rdata_reg <= 8'h00;
      endcase
  end

  a_fail_reset_set: assert property (@(posedge clk_sys) disable iff (rst)
    failure_counter >= fail_drive_threshold |=> fail_reg)
    else $error("fail flag not set");
  a_fail_read_keep: assert property (@(posedge clk_sys) disable iff (rst)
    st_rd && failure_counter >= fail_drive_threshold |=> fail_reg)
    else $error("fail flag cleared wrongly");
  a_cfg_change_flag: assert property (@(posedge clk_sys) disable iff (rst)
    win_cfg_written |=> chg_reg)
    else $error("config change not flagged");
  a_wrong_answer: assert property (@(posedge clk_sys) disable iff (rst)
    cycle_end_reg && !reinit |=> werr_reg == $past(bad_reg))
    else $error("wrong answer flag bad");
  a_seq_single_mode: assert property (@(posedge clk_sys) disable iff (rst)
    cycle_end_reg && mode_reg && !reinit |=> !seq_reg)
    else $error("seq flag in single mode");
  a_timeout_multi: assert property (@(posedge clk_sys) disable iff (rst)
    cycle_end_reg && !mode_reg && !reinit && total_reg < 3'h4
    |=> to_reg)
    else $error("time-out missed");
  a_question_init: assert property (@(posedge clk_sys) disable iff (rst)
    self_test_done |=> question_reg == qa_wd_pkg::QUESTION_RESET)
    else $error("question not reinit");
  a_seed_load: assert property (@(posedge clk_sys) disable iff (rst)
    reset_state && !self_test_done && !mode_chg
    |=> question_reg == $past(qcfg_reg[3:0]))
    else $error("seed not loaded");
  a_status_clear: assert property (@(posedge clk_sys) disable iff (rst)
    st_rd && !cycle_end_reg && !reinit |=> !to_reg && !early_reg)
    else $error("status not cleared");
endmodule : qa_watchdog_question_status

// file: core/qa_wd_pkg.sv
package qa_wd_pkg;
  localparam logic [1:0] REG_QCFG   = 2'h0;
  localparam logic [1:0] REG_QVAL   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_ANSWER = 2'h3;
  localparam int GEN_HI = 7;
  localparam int POLY_HI = 5;
  localparam int SEED_HI = 3;
  localparam int FAIL_BIT = 7;
  localparam int CNT_HI = 6;
  localparam logic [7:0] QCFG_RESET = 8'h0A;
  localparam logic [3:0] QUESTION_RESET = 4'hC;
  localparam logic [1:0] CNT_MULTI_RESET = 2'h3;
  localparam logic [1:0] CNT_SINGLE_RESET = 2'h1;
  localparam int TICK_NS = 550000;
  localparam int CLK_NS = 10;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
endpackage : qa_wd_pkg

// file: core/qa_answer_check.sv
`timescale 1ns/1ns
// expected byte derived from question, byte index and gen_sel
module qa_answer_check
(
  // inputs
  input  wire logic [3:0] question,
  input  wire logic [1:0] index,
  input  wire logic [1:0] gen_sel,
  input  wire logic [7:0] answer,
  // result
  output logic            mismatch
);
  logic [7:0] expected;

  always_comb
  begin
    expected = {question ^ {2'h0, index}, ~question} ^ {6'h00, gen_sel};
    mismatch = (expected != answer);
  end
endmodule : qa_answer_check

// file: tb/mcu_model.sv
`timescale 1ns/1ns
// answering controller on the far side of the register port
module mcu_model
(
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [1:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_reg
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 2'h0;
    reg_wdata = 8'h00;
  end
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_reg;
  endtask : rd
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    // stale data is inverted so it never passes for a fresh byte
    reg_wdata <= ~d;
  endtask : wr
  // n bytes; byte number bad is corrupted on purpose
  task automatic answer(input int n, input int bad);
    logic [7:0] q;
    logic [7:0] b;
    rd(qa_wd_pkg::REG_QVAL, q);
    for (int i = 0; i < n; i++)
    begin
      b = {q[3:0] ^ 4'(i), ~q[3:0]} ^ ((i == bad) ? 8'h01 : 8'h00);
      wr(qa_wd_pkg::REG_ANSWER, b);
    end
  endtask : answer
endmodule : mcu_model

// file: tb/qa_watchdog_question_status_tb_top.sv
`timescale 1ns/1ns
module qa_watchdog_question_status_tb_top;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       reset_state = 1'b0;
  logic       self_test_done = 1'b0;
  logic       window_mode_select = 1'b0;
  logic       win_cfg_written = 1'b0;
  logic [3:0] failure_counter = 4'h0;
  logic [3:0] fail_drive_threshold = 4'h4;
  logic       reg_wr;
  logic       reg_rd;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_reg;
  logic       cycle_end_reg;
  int         num_errors = 0;
  int         checked = 0;
  logic [7:0] cfg_vals [3] = '{8'hC5, 8'h3A, 8'h0A};

  always #5 clk_sys = ~clk_sys;

  qa_watchdog_question_status #(.TICK_CYCLES(2)) i_qa_watchdog_question_status
  (
    .clk_sys(clk_sys), .rst(rst), .reset_state(reset_state),
    .self_test_done(self_test_done),
    .window_mode_select(window_mode_select),
    .win_cfg_written(win_cfg_written),
    .first_window_length(8'h0F), .second_window_length(5'h0F),
    .failure_counter(failure_counter),
    .fail_drive_threshold(fail_drive_threshold),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg),
    .cycle_end_reg(cycle_end_reg)
  );
  mcu_model i_mcu_model
  (
    .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg)
  );

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [1:0] a, input logic [7:0] m,
                     input logic [7:0] e, input string n);
    logic [7:0] d;
    i_mcu_model.rd(a, d);
    chk(n, e, d & m);
  endtask : rdc
  task automatic wait_end;
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      #1 k++;
    end
    while (cycle_end_reg !== 1'b1 && k < 300);
    chk("cycle end", 8'h01, {7'h00, cycle_end_reg});
  endtask : wait_end
  task automatic pulse_test;
    @(posedge clk_sys);
    self_test_done <= 1'b1;
    @(posedge clk_sys);
    self_test_done <= 1'b0;
  endtask : pulse_test
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic t_reset_values;
    rdc(qa_wd_pkg::REG_QCFG, 8'hFF, 8'h0A, "config");
    rdc(qa_wd_pkg::REG_QVAL, 8'hFF, 8'h0C, "question");
    rdc(qa_wd_pkg::REG_ANSWER, 8'hFF, 8'h00, "answer read");
    rdc(qa_wd_pkg::REG_STATUS, 8'hFF, 8'hE0, "status");
    $display("done reset values");
  endtask : t_reset_values
  task automatic t_fail_flag;
    rdc(qa_wd_pkg::REG_STATUS, 8'h80, 8'h00, "fail clr");
    @(posedge clk_sys);
    failure_counter <= 4'h4;
    rdc(qa_wd_pkg::REG_STATUS, 8'h80, 8'h80, "fail set");
    rdc(qa_wd_pkg::REG_STATUS, 8'h80, 8'h80, "fail kept");
    @(posedge clk_sys);
    failure_counter <= 4'h3;
    rdc(qa_wd_pkg::REG_STATUS, 8'h80, 8'h80, "fail held");
    rdc(qa_wd_pkg::REG_STATUS, 8'h80, 8'h00, "fail gone");
    $display("done fail flag");
  endtask : t_fail_flag
  task automatic t_config;
    foreach (cfg_vals[i])
    begin
      i_mcu_model.wr(qa_wd_pkg::REG_QCFG, cfg_vals[i]);
      rdc(qa_wd_pkg::REG_QCFG, 8'hFF, cfg_vals[i], "cfg");
    end
    rdc(qa_wd_pkg::REG_STATUS, 8'h10, 8'h10, "chg set");
    rdc(qa_wd_pkg::REG_STATUS, 8'h10, 8'h00, "chg clr");
    @(posedge clk_sys);
    win_cfg_written <= 1'b1;
    @(posedge clk_sys);
    win_cfg_written <= 1'b0;
    rdc(qa_wd_pkg::REG_STATUS, 8'h10, 8'h10, "chg win");
    i_mcu_model.wr(qa_wd_pkg::REG_QVAL, 8'hFF);
    rdc(qa_wd_pkg::REG_QVAL, 8'hFF, 8'h0C, "question ro");
    $display("done config");
  endtask : t_config
  task automatic t_multi;
    wait_end();
    wait_end();
    rdc(qa_wd_pkg::REG_STATUS, 8'h0F, 8'h06, "none");
    i_mcu_model.answer(4, -1);
    wait_end();
    rdc(qa_wd_pkg::REG_STATUS, 8'h0F, 8'h01, "good");
    i_mcu_model.answer(4, 2);
    wait_end();
    rdc(qa_wd_pkg::REG_STATUS, 8'h0F, 8'h09, "wrong");
    i_mcu_model.answer(3, -1);
    wait_end();
    rdc(qa_wd_pkg::REG_STATUS, 8'h0F, 8'h02, "three");
    $display("done multi answer");
  endtask : t_multi
  task automatic t_single;
    @(posedge clk_sys);
    window_mode_select <= 1'b1;
    rdc(qa_wd_pkg::REG_QVAL, 8'hFF, 8'h0C, "mode q");
    rdc(qa_wd_pkg::REG_STATUS, 8'h70, 8'h30, "mode st");
    wait_end();
    rdc(qa_wd_pkg::REG_STATUS, 8'h0F, 8'h02, "s none");
    i_mcu_model.answer(1, -1);
    wait_end();
    rdc(qa_wd_pkg::REG_STATUS, 8'h0F, 8'h01, "s early");
    pulse_test();
    rdc(qa_wd_pkg::REG_QVAL, 8'hFF, 8'h0C, "test q");
    @(posedge clk_sys);
    reset_state <= 1'b1;
    rdc(qa_wd_pkg::REG_QVAL, 8'hFF, 8'h0A, "seed q");
    @(posedge clk_sys);
    reset_state <= 1'b0;
    $display("done single answer");
  endtask : t_single

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_values();
    t_fail_flag();
    t_config();
    t_multi();
    t_single();
    test_done();
  end
  // about seven cycles of 64 clocks are expected
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end
endmodule : qa_watchdog_question_status_tb_top
